// ### rtl/apac_pkg.sv
// Behaviour
// - Pulses per internal sample come from upper byte of slot pulse count register.
// - Internal samples are summed per slot; count set by 3-bit averaging fields.
// - Pulses behind one output equal pulse count times samples combined.
// - Results appear at internal sample rate divided by samples combined.
// - Four-bit chop pattern sets pulse polarity, repeated every four pulses.
// - Pattern 0xA inverts second and fourth pulses, first and third normal.
// - Inverted pulses are subtracted, normal pulses added, per math register.
// - Math fields bits 2:1 and 6:5 at b01 add pulse one, subtract two.
// - Math fields bits 9:8 and 11:10 at b01 add pulse three, subtract four.
// - Path value 0xB065 bypasses filter and integrator, inverting direct path.
// - Path value 0xAE65 bypasses only the band-pass filter.
// - Integrator acts as buffer when front-end bit 7 and math bit 7 set.
// - Front-end bit 9 selects buffer gain: 0 unity, 1 gain 0.7.
// - Direct mode converts channels one to four, conversions 1 us apart.
// - One slot may run direct mode while the other runs pulsed mode.
package apac_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADC_W = 14;
  localparam int unsigned SAMPLE_W = 24;
  localparam int unsigned RESULT_W = 32;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned CLK_FREQ_MHZ = 125;
  localparam int unsigned CONV_GAP_NS = 1000;
  localparam int unsigned CONV_GAP_CYC = (CONV_GAP_NS * CLK_FREQ_MHZ + 999) / 1000;

  localparam logic [7:0] OFS_SAMPLE_FREQ = 8'h12;
  localparam logic [7:0] OFS_AVG_COUNT = 8'h15;
  localparam logic [7:0] OFS_A_CHOP = 8'h17;
  localparam logic [7:0] OFS_A_OFFSET_CH1 = 8'h18;
  localparam logic [7:0] OFS_A_OFFSET_CH4 = 8'h1B;
  localparam logic [7:0] OFS_B_CHOP = 8'h1D;
  localparam logic [7:0] OFS_B_OFFSET_CH1 = 8'h1E;
  localparam logic [7:0] OFS_B_OFFSET_CH4 = 8'h21;
  localparam logic [7:0] OFS_A_PULSE_COUNT = 8'h31;
  localparam logic [7:0] OFS_B_PULSE_COUNT = 8'h36;
  localparam logic [7:0] OFS_A_FRONTEND = 8'h42;
  localparam logic [7:0] OFS_A_PATH = 8'h43;
  localparam logic [7:0] OFS_B_FRONTEND = 8'h44;
  localparam logic [7:0] OFS_B_PATH = 8'h45;
  localparam logic [7:0] OFS_MATH = 8'h58;

  localparam logic [15:0] REG_RST_VAL = 16'h0000;
  localparam int unsigned PCOUNT_LSB = 8;
  localparam int unsigned AVG_A_LSB = 4;
  localparam int unsigned AVG_B_LSB = 8;
  localparam int unsigned CHOP_LSB = 0;
  localparam int unsigned MATH_A12_LSB = 1;
  localparam int unsigned MATH_B12_LSB = 5;
  localparam int unsigned MATH_A34_LSB = 8;
  localparam int unsigned MATH_B34_LSB = 10;
  localparam int unsigned MATH_BUF_BIT = 7;
  localparam int unsigned FE_BUF_BIT = 7;
  localparam int unsigned FE_GAIN_BIT = 9;
  localparam logic [15:0] PATH_BYPASS_ALL = 16'hB065;
  localparam logic [15:0] PATH_BYPASS_BPF = 16'hAE65;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_PULSE = 3'b010,
    ST_PWAIT = 3'b011,
    ST_CONV  = 3'b100,
    ST_CWAIT = 3'b101,
    ST_NEXT  = 3'b110
  } apac_state_t;
endpackage : apac_pkg

// ### rtl/apac_sample_acc.sv
`timescale 1ns/1ps
`default_nettype none
module apac_sample_acc
  import apac_pkg::*;
#(
  parameter int unsigned IN_W = apac_pkg::SAMPLE_W,
  parameter int unsigned OUT_W = apac_pkg::RESULT_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic sample_valid_i,
  input wire logic signed [IN_W-1:0] sample_i,
  input wire logic [2:0] avg_log2_i,
  output logic signed [OUT_W-1:0] result_o,
  output logic result_valid_o
);
  logic signed [OUT_W-1:0] sum_q;
  logic [7:0] count_q;
  logic [7:0] target;
  logic signed [OUT_W-1:0] sample_ext;
  logic [8:0] seen_q;

  assign target = 8'h01 << avg_log2_i;
  assign sample_ext = OUT_W'(sample_i);

  // Sum 2^n internal samples, emit one result per group
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sum_q <= '0;
      count_q <= 8'h00;
      result_o <= '0;
      result_valid_o <= 1'b0;
    end else if (ce_i) begin
      result_valid_o <= 1'b0;
      if (sample_valid_i) begin
        if (count_q >= target - 8'h01) begin
          result_o <= sum_q + sample_ext;
          result_valid_o <= 1'b1;
          sum_q <= '0;
          count_q <= 8'h00;
        end else begin
          sum_q <= sum_q + sample_ext;
          count_q <= count_q + 8'h01;
        end
      end
    end
  end

  // Independent count of samples between results
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      seen_q <= 9'h000;
    end else if (ce_i) begin
      if (result_valid_o) begin
        seen_q <= {8'h00, sample_valid_i};
      end else if (sample_valid_i) begin
        seen_q <= seen_q + 9'h001;
      end
    end
  end

  AST_RESULT_RATE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (result_valid_o && $past(ce_i) && $stable(avg_log2_i)) |-> (seen_q == {1'b0, target}))
    else $error("result not after the programmed sample count");
endmodule : apac_sample_acc
`default_nettype wire

// ### rtl/apac_top.sv
`timescale 1ns/1ps
`default_nettype none
module apac_top (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [apac_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [apac_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [apac_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic sample_tick_i,
  input wire logic adc_valid_i,
  input wire logic [apac_pkg::ADC_W-1:0] adc_data_i,
  output logic pulse_start_o,
  output logic integ_invert_o,
  output logic conv_start_o,
  output logic [1:0] conv_chan_o,
  output logic slot_b_active_o,
  output logic bpf_bypass_o,
  output logic integ_bypass_o,
  output logic integ_buffer_o,
  output logic slot_buffer_gain_select_o,
  output logic busy_o,
  output logic signed [apac_pkg::RESULT_W-1:0] result_a_o,
  output logic result_a_valid_o,
  output logic signed [apac_pkg::RESULT_W-1:0] result_b_o,
  output logic result_b_valid_o
);
  import apac_pkg::*;

  logic [15:0] sample_freq_q;
  logic [15:0] avg_count_q;
  logic [15:0] chop_q [2];
  logic [15:0] pcount_q [2];
  logic [15:0] fe_q [2];
  logic [15:0] path_q [2];
  logic [15:0] math_q;
  logic [15:0] ofs_q [2][NUM_CH];

  apac_state_t state_q;
  logic slot_q;
  logic [7:0] pidx_q;
  logic [1:0] ch_q;
  logic [7:0] gap_q;
  logic got_q;
  logic signed [SAMPLE_W-1:0] acc_q;
  logic [1:0] smp_vld_q;
  logic signed [SAMPLE_W-1:0] smp_val_q;

  logic [3:0] cur_chop;
  logic [7:0] cur_pcount;
  logic [15:0] cur_fe;
  logic [15:0] cur_path;
  logic [1:0] cur_m12;
  logic [1:0] cur_m34;
  logic [15:0] cur_ofs;
  logic direct_mode;
  logic [1:0] pair_field;
  logic sub_now;
  logic signed [SAMPLE_W-1:0] adc_ext;
  logic signed [SAMPLE_W-1:0] conv_val;
  logic [1:0] b_idx;
  logic in_b_ofs;

  // Settings of the slot in progress
  always_comb begin
    cur_chop = chop_q[slot_q][CHOP_LSB +: 4];
    cur_pcount = pcount_q[slot_q][PCOUNT_LSB +: 8];
    cur_fe = fe_q[slot_q];
    cur_path = path_q[slot_q];
    cur_ofs = ofs_q[slot_q][ch_q];
    if (slot_q) begin
      cur_m12 = math_q[MATH_B12_LSB +: 2];
      cur_m34 = math_q[MATH_B34_LSB +: 2];
    end else begin
      cur_m12 = math_q[MATH_A12_LSB +: 2];
      cur_m34 = math_q[MATH_A34_LSB +: 2];
    end
  end

  assign direct_mode = (cur_path == PATH_BYPASS_ALL) || (cur_path == PATH_BYPASS_BPF);
  // Field bit 1 subtracts the odd pulse, bit 0 the even pulse of a pair
  assign pair_field = pidx_q[1] ? cur_m34 : cur_m12;
  assign sub_now = pidx_q[0] ? pair_field[0] : pair_field[1];
  assign adc_ext = SAMPLE_W'({1'b0, adc_data_i});
  assign conv_val = adc_ext - SAMPLE_W'($signed(cur_ofs));
  assign in_b_ofs = (reg_addr_i >= OFS_B_OFFSET_CH1) && (reg_addr_i <= OFS_B_OFFSET_CH4);
  assign b_idx = 2'(reg_addr_i - OFS_B_OFFSET_CH1);

  // Register writes
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sample_freq_q <= REG_RST_VAL;
      avg_count_q <= REG_RST_VAL;
      math_q <= REG_RST_VAL;
      for (int s = 0; s < 2; s++) begin
        chop_q[s] <= REG_RST_VAL;
        pcount_q[s] <= REG_RST_VAL;
        fe_q[s] <= REG_RST_VAL;
        path_q[s] <= REG_RST_VAL;
        for (int c = 0; c < NUM_CH; c++) begin
          ofs_q[s][c] <= REG_RST_VAL;
        end
      end
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i >= OFS_A_OFFSET_CH1 && reg_addr_i <= OFS_A_OFFSET_CH4) begin
        ofs_q[0][reg_addr_i[1:0]] <= reg_wdata_i;
      end
      if (in_b_ofs) begin
        ofs_q[1][b_idx] <= reg_wdata_i;
      end
      unique case (reg_addr_i)
        OFS_SAMPLE_FREQ: sample_freq_q <= reg_wdata_i;
        OFS_AVG_COUNT: avg_count_q <= reg_wdata_i;
        OFS_A_CHOP: chop_q[0] <= reg_wdata_i;
        OFS_B_CHOP: chop_q[1] <= reg_wdata_i;
        OFS_A_PULSE_COUNT: pcount_q[0] <= reg_wdata_i;
        OFS_B_PULSE_COUNT: pcount_q[1] <= reg_wdata_i;
        OFS_A_FRONTEND: fe_q[0] <= reg_wdata_i;
        OFS_B_FRONTEND: fe_q[1] <= reg_wdata_i;
        OFS_A_PATH: path_q[0] <= reg_wdata_i;
        OFS_B_PATH: path_q[1] <= reg_wdata_i;
        OFS_MATH: math_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Register reads, unmapped reads return zero
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (ce_i && reg_rd_i) begin
      if (reg_addr_i >= OFS_A_OFFSET_CH1 && reg_addr_i <= OFS_A_OFFSET_CH4) begin
        reg_rdata_o <= ofs_q[0][reg_addr_i[1:0]];
      end else if (in_b_ofs) begin
        reg_rdata_o <= ofs_q[1][b_idx];
      end else begin
        unique case (reg_addr_i)
          OFS_SAMPLE_FREQ: reg_rdata_o <= sample_freq_q;
          OFS_AVG_COUNT: reg_rdata_o <= avg_count_q;
          OFS_A_CHOP: reg_rdata_o <= chop_q[0];
          OFS_B_CHOP: reg_rdata_o <= chop_q[1];
          OFS_A_PULSE_COUNT: reg_rdata_o <= pcount_q[0];
          OFS_B_PULSE_COUNT: reg_rdata_o <= pcount_q[1];
          OFS_A_FRONTEND: reg_rdata_o <= fe_q[0];
          OFS_B_FRONTEND: reg_rdata_o <= fe_q[1];
          OFS_A_PATH: reg_rdata_o <= path_q[0];
          OFS_B_PATH: reg_rdata_o <= path_q[1];
          OFS_MATH: reg_rdata_o <= math_q;
          default: reg_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // Slot sequencer: slot A then slot B on each sampling event
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
      slot_q <= 1'b0;
      pidx_q <= 8'h00;
      ch_q <= 2'b00;
      gap_q <= 8'h00;
      got_q <= 1'b0;
      acc_q <= '0;
      smp_vld_q <= 2'b00;
      smp_val_q <= '0;
      pulse_start_o <= 1'b0;
      integ_invert_o <= 1'b0;
      conv_start_o <= 1'b0;
      conv_chan_o <= 2'b00;
    end else if (ce_i) begin
      pulse_start_o <= 1'b0;
      conv_start_o <= 1'b0;
      smp_vld_q <= 2'b00;
      unique case (state_q)
        ST_IDLE: begin
          if (sample_tick_i) begin
            slot_q <= 1'b0;
            state_q <= ST_START;
          end
        end
        ST_START: begin
          acc_q <= '0;
          pidx_q <= 8'h00;
          ch_q <= 2'b00;
          if (direct_mode) begin
            state_q <= ST_CONV;
          end else if (cur_pcount == 8'h00) begin
            state_q <= ST_NEXT;
          end else begin
            state_q <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          pulse_start_o <= 1'b1;
          integ_invert_o <= cur_chop[pidx_q[1:0]];
          state_q <= ST_PWAIT;
        end
        ST_PWAIT: begin
          if (adc_valid_i) begin
            acc_q <= sub_now ? acc_q - adc_ext : acc_q + adc_ext;
            if (pidx_q == cur_pcount - 8'h01) begin
              smp_vld_q[slot_q] <= 1'b1;
              smp_val_q <= sub_now ? acc_q - adc_ext : acc_q + adc_ext;
              state_q <= ST_NEXT;
            end else begin
              pidx_q <= pidx_q + 8'h01;
              state_q <= ST_PULSE;
            end
          end
        end
        ST_CONV: begin
          conv_start_o <= 1'b1;
          conv_chan_o <= ch_q;
          gap_q <= 8'(CONV_GAP_CYC - 2);
          got_q <= 1'b0;
          state_q <= ST_CWAIT;
        end
        ST_CWAIT: begin
          if (adc_valid_i && !got_q) begin
            got_q <= 1'b1;
            acc_q <= acc_q + conv_val;
          end
          if (gap_q != 8'h00) begin
            gap_q <= gap_q - 8'h01;
          end else if (got_q) begin
            if (ch_q == 2'(NUM_CH - 1)) begin
              smp_vld_q[slot_q] <= 1'b1;
              smp_val_q <= acc_q;
              state_q <= ST_NEXT;
            end else begin
              ch_q <= ch_q + 2'b01;
              state_q <= ST_CONV;
            end
          end
        end
        ST_NEXT: begin
          if (!slot_q) begin
            slot_q <= 1'b1;
            state_q <= ST_START;
          end else begin
            slot_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Analog path controls for the slot in progress
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      slot_b_active_o <= 1'b0;
      bpf_bypass_o <= 1'b0;
      integ_bypass_o <= 1'b0;
      integ_buffer_o <= 1'b0;
      slot_buffer_gain_select_o <= 1'b0;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      slot_b_active_o <= slot_q;
      bpf_bypass_o <= direct_mode;
      integ_bypass_o <= (cur_path == PATH_BYPASS_ALL);
      integ_buffer_o <= cur_fe[FE_BUF_BIT] && math_q[MATH_BUF_BIT];
      slot_buffer_gain_select_o <= cur_fe[FE_GAIN_BIT];
      busy_o <= (state_q != ST_IDLE);
    end
  end

  apac_sample_acc #(
    .IN_W(SAMPLE_W),
    .OUT_W(RESULT_W)
  ) u_acc_a (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .sample_valid_i(smp_vld_q[0]),
    .sample_i(smp_val_q),
    .avg_log2_i(avg_count_q[AVG_A_LSB +: 3]),
    .result_o(result_a_o),
    .result_valid_o(result_a_valid_o)
  );

  apac_sample_acc #(
    .IN_W(SAMPLE_W),
    .OUT_W(RESULT_W)
  ) u_acc_b (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .sample_valid_i(smp_vld_q[1]),
    .sample_i(smp_val_q),
    .avg_log2_i(avg_count_q[AVG_B_LSB +: 3]),
    .result_o(result_b_o),
    .result_valid_o(result_b_valid_o)
  );

  // Cycles since the last conversion request
  logic [15:0] since_conv_q;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      since_conv_q <= 16'h0000;
    end else if (ce_i && conv_start_o) begin
      since_conv_q <= 16'h0001;
    end else if (ce_i && since_conv_q != 16'hFFFF) begin
      since_conv_q <= since_conv_q + 16'h0001;
    end
  end

  sequence seq_pulse_take;
    (state_q == ST_PWAIT) && adc_valid_i && ce_i;
  endsequence

  sequence seq_path_latch;
    ce_i && (state_q != ST_IDLE);
  endsequence

  AST_CHOP_REPEAT: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    pulse_start_o |-> (integ_invert_o == cur_chop[pidx_q[1:0]]))
    else $error("pulse polarity does not follow chop pattern");

  AST_CHOP_A_PATTERN: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (pulse_start_o && cur_chop == 4'hA) |-> (integ_invert_o == pidx_q[0]))
    else $error("pattern 0xA did not invert only even pulses");

  AST_MATH_FIRST_PAIR: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (seq_pulse_take and (!pidx_q[1] && cur_m12 == 2'b01))
    |=> (acc_q == ($past(pidx_q[0]) ? $past(acc_q) - $past(adc_ext)
                                    : $past(acc_q) + $past(adc_ext))))
    else $error("first pair math sign wrong");

  AST_MATH_SECOND_PAIR: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (seq_pulse_take and (pidx_q[1] && cur_m34 == 2'b01))
    |=> (acc_q == ($past(pidx_q[0]) ? $past(acc_q) - $past(adc_ext)
                                    : $past(acc_q) + $past(adc_ext))))
    else $error("second pair math sign wrong");

  AST_PULSE_COUNT: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (seq_pulse_take and (pidx_q == cur_pcount - 8'h01)) |=> (state_q == ST_NEXT) && (|smp_vld_q))
    else $error("sample not closed after programmed pulse count");

  AST_CONV_SPACING: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (conv_start_o && conv_chan_o != 2'b00) |-> (since_conv_q >= 16'(CONV_GAP_CYC)))
    else $error("conversions closer than 1 us");

  AST_BYPASS_ALL: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    seq_path_latch ##1 1'b1 |-> (integ_bypass_o == ($past(cur_path) == PATH_BYPASS_ALL))
                                && (bpf_bypass_o || !integ_bypass_o))
    else $error("full bypass not applied");

  AST_BYPASS_BPF: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    seq_path_latch ##1 ($past(cur_path) == PATH_BYPASS_BPF) |-> (bpf_bypass_o && !integ_bypass_o))
    else $error("filter-only bypass not applied");

  AST_BUFFER_MODE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    seq_path_latch ##1 1'b1 |->
      (integ_buffer_o == ($past(cur_fe[FE_BUF_BIT]) && $past(math_q[MATH_BUF_BIT]))))
    else $error("integrator buffer enable wrong");

  AST_BUFFER_GAIN: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    seq_path_latch ##1 1'b1 |-> (slot_buffer_gain_select_o == $past(cur_fe[FE_GAIN_BIT])))
    else $error("buffer gain select wrong");
endmodule : apac_top
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import apac_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = 8'h00;
  logic [DATA_W-1:0] reg_wdata_i = 16'h0000;
  logic sample_tick_i = 1'b0;
  logic adc_valid_i = 1'b0;
  logic [ADC_W-1:0] adc_data_i = 14'h0000;
  logic [DATA_W-1:0] reg_rdata_o;
  logic pulse_start_o, integ_invert_o, conv_start_o, slot_b_active_o, busy_o;
  logic bpf_bypass_o, integ_bypass_o, integ_buffer_o, slot_buffer_gain_select_o;
  logic [1:0] conv_chan_o;
  logic signed [RESULT_W-1:0] result_a_o, result_b_o;
  logic result_a_valid_o, result_b_valid_o;
  logic r_slot [64];
  logic r_inv [64];
  logic r_conv [64];
  logic [1:0] r_chan [64];
  logic [3:0] r_path [64];
  int r_time [64];
  logic signed [31:0] res_a, res_b;
  int n_req, got_a, got_b;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] ofs [19] = '{8'h12, 8'h15, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1D, 8'h1E,
    8'h1F, 8'h20, 8'h21, 8'h31, 8'h36, 8'h42, 8'h43, 8'h44, 8'h45, 8'h58};

  apac_top uut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .sample_tick_i(sample_tick_i), .adc_valid_i(adc_valid_i),
    .adc_data_i(adc_data_i), .pulse_start_o(pulse_start_o), .integ_invert_o(integ_invert_o),
    .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o), .slot_b_active_o(slot_b_active_o),
    .bpf_bypass_o(bpf_bypass_o), .integ_bypass_o(integ_bypass_o),
    .integ_buffer_o(integ_buffer_o), .slot_buffer_gain_select_o(slot_buffer_gain_select_o),
    .busy_o(busy_o), .result_a_o(result_a_o), .result_a_valid_o(result_a_valid_o),
    .result_b_o(result_b_o), .result_b_valid_o(result_b_valid_o)
  );

  always #4 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      conclude();
    end
  end

  function automatic logic [13:0] dval(input int k);
    return 14'(256 + k * 37);
  endfunction : dval

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    d = reg_rdata_o;
  endtask : rd

  // One sampling event; each request answered two cycles later
  task automatic run_tick();
    int pend;
    int idle;
    pend = 0;
    idle = 0;
    n_req = 0;
    got_a = 0;
    got_b = 0;
    @(posedge sys_clk_i);
    sample_tick_i <= 1'b1;
    @(posedge sys_clk_i);
    sample_tick_i <= 1'b0;
    while (idle < 6) begin
      @(negedge sys_clk_i);
      if (pulse_start_o === 1'b1 || conv_start_o === 1'b1) begin
        r_slot[n_req] = slot_b_active_o;
        r_inv[n_req] = integ_invert_o;
        r_conv[n_req] = conv_start_o;
        r_chan[n_req] = conv_chan_o;
        r_path[n_req] = {bpf_bypass_o, integ_bypass_o, integ_buffer_o, slot_buffer_gain_select_o};
        r_time[n_req] = cycles;
        pend = 2;
      end
      if (result_a_valid_o === 1'b1) begin
        res_a = result_a_o;
        got_a++;
      end
      if (result_b_valid_o === 1'b1) begin
        res_b = result_b_o;
        got_b++;
      end
      idle = (busy_o === 1'b0 && pend == 0) ? idle + 1 : 0;
      @(posedge sys_clk_i);
      adc_valid_i <= (pend == 1);
      adc_data_i <= dval(n_req);
      if (pend == 1) n_req++;
      if (pend > 0) pend--;
    end
  endtask : run_tick

  task automatic sum_pulses(input logic slot, input logic [3:0] chop, input logic [1:0] f12,
      input logic [1:0] f34, inout logic signed [31:0] acc, output int cnt);
    logic [1:0] f;
    cnt = 0;
    for (int k = 0; k < n_req; k++) begin
      if (r_slot[k] === slot) begin
        f = (cnt % 4 < 2) ? f12 : f34;
        chk("integ_invert_o", {31'b0, chop[cnt % 4]}, {31'b0, r_inv[k]});
        if ((cnt % 2 == 0) ? f[1] : f[0]) acc = acc - dval(k);
        else acc = acc + dval(k);
        cnt++;
      end
    end
  endtask : sum_pulses

  task automatic test_regs();
    logic [15:0] d;
    for (int i = 0; i < 19; i++) begin
      rd(ofs[i], d);
      chk("reset value", 32'h0, {16'h0, d});
      wr(ofs[i], {ofs[i], ~ofs[i]});
    end
    wr(8'h00, 16'hFFFF);
    rd(8'h00, d);
    chk("unmapped", 32'h0, {16'h0, d});
    for (int i = 0; i < 19; i++) begin
      rd(ofs[i], d);
      chk("readback", {16'h0, ofs[i], ~ofs[i]}, {16'h0, d});
      wr(ofs[i], 16'h0000);
    end
    $display("test_regs done");
  endtask : test_regs

  task automatic test_chop();
    logic signed [31:0] ea, eb;
    int na, nb;
    wr(OFS_A_PULSE_COUNT, 16'h0600);
    wr(OFS_B_PULSE_COUNT, 16'h0200);
    for (int i = 3; i < 12; i++) begin
      if (ofs[i] != OFS_B_CHOP) wr(ofs[i], 16'h0000);
    end
    wr(OFS_SAMPLE_FREQ, 16'h0190);
    wr(OFS_A_CHOP, 16'h000A);
    wr(OFS_B_CHOP, 16'h0005);
    wr(OFS_MATH, 16'h0142);
    wr(OFS_AVG_COUNT, 16'h0010);
    ea = 0;
    for (int t = 0; t < 2; t++) begin
      eb = 0;
      run_tick();
      sum_pulses(1'b0, 4'hA, 2'b01, 2'b01, ea, na);
      sum_pulses(1'b1, 4'h5, 2'b10, 2'b00, eb, nb);
      chk("pulses a", 32'd6, na);
      chk("pulses b", 32'd2, nb);
      chk("valid a", t, got_a);
      chk("valid b", 32'd1, got_b);
      chk("result b", eb, res_b);
    end
    chk("result a", ea, res_a);
    $display("test_chop done");
  endtask : test_chop

  task automatic test_direct();
    logic signed [31:0] ea, eb;
    int j, nb;
    wr(OFS_AVG_COUNT, 16'h0000);
    wr(OFS_MATH, 16'h0000);
    wr(OFS_B_CHOP, 16'h0000);
    wr(OFS_A_PATH, PATH_BYPASS_ALL);
    wr(8'h19, 16'h0010);
    run_tick();
    ea = 0;
    eb = 0;
    j = 0;
    for (int k = 0; k < n_req; k++) begin
      if (r_slot[k] === 1'b0) begin
        chk("conv a", 32'd1, r_conv[k]);
        chk("chan", j, r_chan[k]);
        chk("path a", 4'hC, r_path[k]);
        if (j > 0) chk("gap", CONV_GAP_CYC, r_time[k] - r_time[k-1]);
        ea = ea + dval(k) - ((j == 1) ? 16 : 0);
        j++;
      end else begin
        chk("path b", 4'h0, r_path[k]);
      end
    end
    sum_pulses(1'b1, 4'h0, 2'b00, 2'b00, eb, nb);
    chk("chans", 32'd4, j);
    chk("result a", ea, res_a);
    chk("result b", eb, res_b);
    $display("test_direct done");
  endtask : test_direct

  task automatic test_buffer();
    logic [15:0] fe [3] = '{16'h0280, 16'h0280, 16'h0080};
    logic [15:0] mt [3] = '{16'h0000, 16'h0080, 16'h0080};
    logic [3:0] ex [3] = '{4'h9, 4'hB, 4'hA};
    wr(OFS_B_PULSE_COUNT, 16'h0000);
    wr(OFS_A_PATH, PATH_BYPASS_BPF);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_A_FRONTEND, fe[i]);
      wr(OFS_MATH, mt[i]);
      run_tick();
      chk("path a", ex[i], r_path[0]);
      chk("no b", 32'd0, got_b);
    end
    $display("test_buffer done");
  endtask : test_buffer

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    test_regs();
    test_chop();
    test_direct();
    test_buffer();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
